// [tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, op_set_pulse, reading, writing, forward_motion_active;
	logic seven_track_select, tape_mark_operation, parity_odd_select, ctrl_ready;
	logic drive_read_strobe, drive_char_clock, controller_data_strobe, char_buffer_ready;
	logic check_generator_pulse, crc_next_indication, lrc_next_indication, crc_error_out;
	logic lrc_error_out, parity_error_out, file_mark_found_out, more_than_two_strobes;
	logic record_active, record_end_flag, read_clear_pulse;
	trrc_pkg::trrc_char_t read_lines, ctrl_char, latched_read_lines;
	int fail_count, cmp_count;
	trrc_top i_trrc_top (.clk, .rst, .drive_read_strobe, .drive_char_clock, .read_lines,
		.op_set_pulse, .reading, .writing, .forward_motion_active, .seven_track_select,
		.tape_mark_operation, .parity_odd_select, .ctrl_ready, .controller_data_strobe,
		.ctrl_char, .char_buffer_ready, .check_generator_pulse, .latched_read_lines,
		.crc_next_indication, .lrc_next_indication, .crc_error_out, .lrc_error_out,
		.parity_error_out, .file_mark_found_out, .more_than_two_strobes, .record_active,
		.record_end_flag, .read_clear_pulse);
	trrc_drive_model i_trrc_drive_model (.clk, .drive_read_strobe, .drive_char_clock,
		.read_lines);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	function automatic trrc_pkg::trrc_char_t mk(input logic [7:0] b);
		return {~^b, b};
	endfunction : mk
	function automatic logic sel(input int s);
		return s == 0 ? read_clear_pulse : s == 1 ? record_end_flag : file_mark_found_out;
	endfunction : sel
	task automatic wait_hi(input int s, output int n);
		n = 0;
		while (sel(s) !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
	endtask : wait_hi
	task automatic opset(input logic sev, input logic fwd);
		@(posedge clk);
		i_trrc_drive_model.run <= 1'b0;
		seven_track_select <= sev;
		forward_motion_active <= fwd;
		reading <= 1'b1;
		op_set_pulse <= 1'b1;
		@(posedge clk);
		op_set_pulse <= 1'b0;
		i_trrc_drive_model.run <= 1'b1;
	endtask : opset
	task automatic pop(input trrc_pkg::trrc_char_t exp);
		@(posedge clk);
		chk("ctrl char", exp, ctrl_char);
		ctrl_ready <= 1'b1;
		@(posedge clk);
		ctrl_ready <= 1'b0;
	endtask : pop
	task automatic t_record(input logic fwd, input logic bad);
		trrc_pkg::trrc_char_t c[4], crcc, lrcc;
		int n;
		c = '{mk(8'h41), mk(8'h42), mk(8'h44), mk(8'h48)};
		// check char with wrong parity: must not count as a parity fault
		crcc = {^8'ha5, 8'ha5};
		lrcc = c[0] ^ c[1] ^ c[2] ^ c[3] ^ crcc ^ {8'h00, bad};
		opset(1'b0, fwd);
		ctrl_ready <= 1'b0;
		foreach (c[i])
		begin
			i_trrc_drive_model.send(c[i]);
			chk("latched", c[i], latched_read_lines);
			if (i == 1)
				chk("buffer ready", 9'h000, 9'(char_buffer_ready));
		end
		chk("more than two", 9'h001, 9'(more_than_two_strobes));
		chk("record active", 9'h001, 9'(record_active));
		pop(c[0]);
		pop(c[1]);
		@(posedge clk);
		chk("data strobe", 9'h000, 9'(controller_data_strobe));
		ctrl_ready <= 1'b1;
		repeat (25) @(posedge clk);
		chk("crc next", 9'h001, 9'(crc_next_indication));
		i_trrc_drive_model.send(crcc);
		chk("lrc next", 9'h001, 9'(lrc_next_indication));
		chk("crc next", 9'h000, 9'(crc_next_indication));
		i_trrc_drive_model.send(lrcc);
		chk("record end", 9'h001, 9'(record_end_flag));
		chk("lrc next", 9'h000, 9'(lrc_next_indication));
		reading <= 1'b0;
		wait_hi(0, n);
		chk("short delay", 9'h001, 9'(n > 45 && n < 75));
		chk("lrc error", 9'(fwd & bad), 9'(lrc_error_out));
		if (!fwd)
			chk("crc error", 9'h000, 9'(crc_error_out));
		chk("parity error", 9'h000, 9'(parity_error_out));
		chk("maint lrc", {8'h00, bad}, ctrl_char);
		chk("file mark", 9'h000, 9'(file_mark_found_out));
	endtask : t_record
	task automatic t_write;
		opset(1'b0, 1'b0);
		writing <= 1'b1;
		i_trrc_drive_model.send(mk(8'h41) ^ 9'h100);
		i_trrc_drive_model.send(mk(8'h42));
		i_trrc_drive_model.send(mk(8'h44));
		repeat (80) @(posedge clk);
		chk("crc next", 9'h000, 9'(crc_next_indication));
		chk("record end", 9'h000, 9'(record_end_flag));
		chk("parity error", 9'h001, 9'(parity_error_out));
		writing <= 1'b0;
	endtask : t_write
	task automatic t_mark(input int cnt);
		int n;
		opset(1'b0, 1'b0);
		repeat (cnt) i_trrc_drive_model.send(mk(8'h13));
		wait_hi(2, n);
		chk("file mark", 9'(cnt == 2), 9'(file_mark_found_out));
		chk("record active", 9'h001, 9'(record_active));
		chk("more than two", 9'(cnt > 2), 9'(more_than_two_strobes));
	endtask : t_mark
	// seven-track, or nine-track mark operation when sev is low
	task automatic t_seven(input logic sev);
		int n;
		tape_mark_operation <= ~sev;
		opset(sev, 1'b0);
		repeat (3) i_trrc_drive_model.send(mk(8'h21));
		repeat (25) @(posedge clk);
		chk("lrc next", 9'h001, 9'(lrc_next_indication));
		chk("crc next", 9'h000, 9'(crc_next_indication));
		// zero check char: no drive strobe ever comes
		wait_hi(1, n);
		chk("record end", 9'h001, 9'(record_end_flag));
		wait_hi(0, n);
		chk("long delay", 9'h001, 9'(n > 180 && n < 205));
		tape_mark_operation <= 1'b0;
	endtask : t_seven
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	initial
	begin
		fail_count = 0;
		cmp_count = 0;
		rst = 1'b1;
		op_set_pulse = 1'b0;
		reading = 1'b0;
		writing = 1'b0;
		forward_motion_active = 1'b0;
		seven_track_select = 1'b0;
		tape_mark_operation = 1'b0;
		parity_odd_select = 1'b1;
		ctrl_ready = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_record(1'b0, 1'b1);
		t_record(1'b1, 1'b1);
		t_record(1'b1, 1'b0);
		t_write;
		t_mark(2);
		t_mark(3);
		t_seven(1'b1);
		t_seven(1'b0);
		print_verdict;
	end
	// the whole run needs about 1700 cycles
	initial
	begin
		#100000;
		fail_count++;
		print_verdict;
	end
endmodule : tb

// [trrc_drive_model.sv]
module trrc_drive_model (
	input wire logic clk,
	output logic drive_read_strobe,
	output logic drive_char_clock,
	output trrc_pkg::trrc_char_t read_lines
);
	timeunit 1ns;
	timeprecision 1ns;
	logic run;
	int ph;
	initial
	begin
		run = 1'b0;
		ph = 0;
		drive_read_strobe = 1'b0;
		drive_char_clock = 1'b0;
		read_lines = '0;
	end
	// char clock only while tape is at speed; parked low otherwise
	always @(posedge clk)
	begin
		ph <= (ph + 1) % 4;
		if (ph == 3)
			drive_char_clock <= run & ~drive_char_clock;
	end
	task automatic send(input trrc_pkg::trrc_char_t c);
		@(posedge clk);
		read_lines <= c;
		repeat (2) @(posedge clk);
		drive_read_strobe <= 1'b1;
		repeat (4) @(posedge clk);
		drive_read_strobe <= 1'b0;
		// released lines must not keep showing the last character
		read_lines <= ~c;
		repeat (2) @(posedge clk);
	endtask : send
endmodule : trrc_drive_model

// [trrc_pair_buf.sv]
module trrc_pair_buf #(
	parameter int W = 9
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_reg [2];
	logic [W-1:0] mem_next [2];
	logic wr_reg, wr_next, rd_reg, rd_next;
	logic [1:0] cnt_reg, cnt_next;
	logic push, pop;

	always_comb
	begin
		in_ready = (cnt_reg != 2'h2);
		out_valid = (cnt_reg != 2'h0);
		out_data = mem_reg[rd_reg];
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		if (push)
		begin
			mem_next[wr_reg] = in_data;
			wr_next = ~wr_reg;
		end
		if (pop)
			rd_next = ~rd_reg;
		cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end
		else
		begin
			mem_reg <= mem_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule : trrc_pair_buf

// [trrc_pkg.sv]
// What this block does
// [R1] each drive strobe latches and clocks checks; strobes controller unless the buffer is full
// [R2] output mux: read char when reading, else LRC
// [R3] nonzero CRC compare in CRC phase flags error
// [R4] nonzero LRC compare in LRC phase flags error
// [R5] CRC/LRC errors only during forward motion
// [R6] body parity checked, quiet during CRC/LRC phases
// [R7] file mark: two mark chars, eight blanks
// [R8] mark-char flag set at start, never re-set
// [R9] count two enables gap detector, three resets it
// [R10] gap eight flags file mark; third strobe before gap eight cancels
// [R11] record active from many strobes or file mark
// [R12] end counter preset 8; three blanks start end
// [R13] nine-track three-count sets CRC phase flag
// [R14] CRC strobe sets LRC phase, clears CRC phase
// [R15] LRC strobe clears LRC phase, sets record end
// [R16] end counter overflow feeds decision delay, clear pulse
// [R17] strobes in delay reload; phases never repeat
// [R18] character clocks ignored while writing
// [R19] count six in a phase makes artificial strobe
// [R20] delay counter loads one if no LRC phase
// [R21] seven-track or mark op skips CRC phase
// [R22] mark operation always uses the long delay
// [R23] drive strobes each character after skew delay
// [R24] operation set pulse initialises all record state except the latch and the character buffer
package trrc_pkg;
	typedef struct packed
	{
		logic parity;
		logic [7:0] bits;
	} trrc_char_t;

	localparam int CHAR_W = 9;
	localparam int SYNC_W = 11;
	localparam int SYNC_STB = 10;
	localparam int SYNC_CLK = 9;
	// end counter runs from its preset; it overflows into zero after eight clocks
	localparam logic [3:0] EOR_PRESET = 4'h8;
	localparam logic [3:0] EOR_THREE = 4'hb;
	localparam logic [3:0] EOR_SIX = 4'he;
	localparam logic [3:0] EOR_LAST = 4'hf;
	localparam logic [3:0] EOR_STEP = 4'h1;
	localparam logic [1:0] STB_GAP_ON = 2'h2;
	localparam logic [1:0] STB_MANY = 2'h3;
	localparam logic [1:0] STB_STEP = 2'h1;
	localparam logic [3:0] GAP_BLANKS = 4'h8;
	localparam logic [3:0] GAP_STEP = 4'h1;
	localparam logic [7:0] FMK_CHAR_9 = 8'h13;
	localparam logic [7:0] FMK_CHAR_7 = 8'h0f;
	// feedback taps of the check generator; plain default
	localparam logic [8:0] CRC_TAPS = 9'h079;

	function automatic logic trrc_nonzero(input logic [CHAR_W-1:0] v);
		return |v;
	endfunction : trrc_nonzero
endpackage : trrc_pkg

// [trrc_top.sv]
module trrc_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic drive_read_strobe,
	input wire logic drive_char_clock,
	input wire trrc_pkg::trrc_char_t read_lines,
	input wire logic op_set_pulse,
	input wire logic reading,
	input wire logic writing,
	input wire logic forward_motion_active,
	input wire logic seven_track_select,
	input wire logic tape_mark_operation,
	input wire logic parity_odd_select,
	input wire logic ctrl_ready,
	output logic controller_data_strobe,
	output trrc_pkg::trrc_char_t ctrl_char,
	output logic char_buffer_ready,
	output logic check_generator_pulse,
	output trrc_pkg::trrc_char_t latched_read_lines,
	output logic crc_next_indication,
	output logic lrc_next_indication,
	output logic crc_error_out,
	output logic lrc_error_out,
	output logic parity_error_out,
	output logic file_mark_found_out,
	output logic more_than_two_strobes,
	output logic record_active,
	output logic record_end_flag,
	output logic read_clear_pulse
);
	logic [trrc_pkg::SYNC_W-1:0] sync1_reg, sync2_reg;
	logic [1:0] prev_reg, prev_next;
	trrc_pkg::trrc_char_t latch_reg, latch_next, ch;
	trrc_pkg::trrc_char_t buf_out;
	logic [8:0] crc_reg, crc_next, lrc_reg, lrc_next;
	logic crc_flag_reg, crc_flag_next, lrc_flag_reg, lrc_flag_next;
	logic end_reg, end_next;
	logic [1:0] stb_reg, stb_next;
	logic many_reg, many_next;
	logic [3:0] gap_reg, gap_next;
	logic seen_reg, seen_next, fmk_reg, fmk_next;
	logic [3:0] eor_reg, eor_next, eor_inc;
	logic dd_reg, dd_next, done_reg, done_next;
	logic crc_err_reg, crc_err_next, lrc_err_reg, lrc_err_next;
	logic par_err_reg, par_err_next;
	logic chk_reg, chk_next, clr_reg, clr_next;
	logic drv_stb, char_tick, eor_run, artificial, three_evt, overflow, comp;
	logic fmk_char;

	// pins cross into clk here; the first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= {drive_read_strobe, drive_char_clock, read_lines};
			sync2_reg <= sync1_reg;
		end
	end

	always_comb
	begin
		prev_next = {sync2_reg[trrc_pkg::SYNC_STB], sync2_reg[trrc_pkg::SYNC_CLK]};
		drv_stb = sync2_reg[trrc_pkg::SYNC_STB] & ~prev_reg[1]; // see [R23]
		// a gap seen while writing may be a tape flaw, not an end
		char_tick = sync2_reg[trrc_pkg::SYNC_CLK] & ~prev_reg[0] & ~writing; // see [R18]
		record_active = many_reg | fmk_reg; // see [R11]
		eor_inc = eor_reg + trrc_pkg::EOR_STEP;
		eor_run = char_tick & record_active;
		// zero check characters leave no strobe; stand in for them
		artificial = eor_run & ~drv_stb & (crc_flag_reg | lrc_flag_reg)
			& (eor_inc == trrc_pkg::EOR_SIX); // see [R19]
		three_evt = eor_run & ~drv_stb & ~crc_flag_reg & ~lrc_flag_reg & ~end_reg
			& (eor_inc == trrc_pkg::EOR_THREE); // see [R12]
		overflow = eor_run & ~drv_stb & (eor_reg == trrc_pkg::EOR_LAST);
		comp = drv_stb | artificial; // see [R1]
		ch = drv_stb ? trrc_pkg::trrc_char_t'(sync2_reg[trrc_pkg::CHAR_W-1:0]) : '0;
		fmk_char = ch.bits == (seven_track_select ? trrc_pkg::FMK_CHAR_7 : trrc_pkg::FMK_CHAR_9);

		latch_next = latch_reg;
		crc_next = crc_reg;
		lrc_next = lrc_reg;
		crc_flag_next = crc_flag_reg;
		lrc_flag_next = lrc_flag_reg;
		end_next = end_reg;
		stb_next = stb_reg;
		many_next = many_reg;
		gap_next = gap_reg;
		seen_next = seen_reg;
		fmk_next = fmk_reg;
		eor_next = eor_reg;
		dd_next = dd_reg;
		done_next = done_reg;
		crc_err_next = crc_err_reg;
		lrc_err_next = lrc_err_reg;
		par_err_next = par_err_reg;
		chk_next = comp; // see [R1]
		clr_next = 1'b0;

		if (comp)
		begin
			latch_next = ch; // see [R1]
			eor_next = trrc_pkg::EOR_PRESET; // see [R12]
			lrc_next = lrc_reg ^ ch;
			if (crc_flag_reg)
			begin
				crc_next = crc_reg ^ ch;
				if (forward_motion_active & trrc_pkg::trrc_nonzero(crc_reg ^ ch))
					crc_err_next = 1'b1; // see [R3] see [R5]
				lrc_flag_next = 1'b1; // see [R14]
				crc_flag_next = 1'b0; // see [R14]
			end
			else if (lrc_flag_reg)
			begin
				if (forward_motion_active & trrc_pkg::trrc_nonzero(lrc_reg ^ ch))
					lrc_err_next = 1'b1; // see [R4] see [R5]
				lrc_flag_next = 1'b0; // see [R15]
				end_next = 1'b1; // see [R15]
			end
			else
			begin
				crc_next = {crc_reg[7:0], 1'b0} ^ ({9{crc_reg[8]}} & trrc_pkg::CRC_TAPS) ^ ch;
				if ((^ch) != parity_odd_select)
					par_err_next = 1'b1; // see [R6]
			end
		end
		else if (eor_run)
			eor_next = eor_inc;

		if (three_evt)
		begin
			// no check character precedes the LRC in these modes
			if (seven_track_select | tape_mark_operation)
				lrc_flag_next = 1'b1; // see [R21]
			else
				crc_flag_next = 1'b1; // see [R13]
		end

		if (lrc_flag_next | end_next)
			crc_flag_next = 1'b0; // see [R15] see [R17]

		if (drv_stb)
		begin
			seen_next = seen_reg & fmk_char; // see [R8]
			if (stb_reg != trrc_pkg::STB_MANY)
				stb_next = stb_reg + trrc_pkg::STB_STEP;
			if (stb_reg == trrc_pkg::STB_GAP_ON)
			begin
				many_next = 1'b1; // see [R9]
				gap_next = '0; // see [R9]
				if (gap_reg != trrc_pkg::GAP_BLANKS)
					seen_next = 1'b0; // see [R10]
			end
			// long delay unless the LRC phase was already running outside a mark operation
			dd_next = ~lrc_flag_reg | tape_mark_operation; // see [R20] see [R22]
			done_next = 1'b0; // see [R17]
		end
		else if (char_tick & (stb_reg == trrc_pkg::STB_GAP_ON) & (gap_reg != trrc_pkg::GAP_BLANKS))
		begin
			gap_next = gap_reg + trrc_pkg::GAP_STEP; // see [R9]
			if (seen_reg & (gap_next == trrc_pkg::GAP_BLANKS))
				fmk_next = 1'b1; // see [R7] see [R10]
		end

		if (overflow & end_reg & ~done_reg)
		begin
			if (dd_reg)
				dd_next = 1'b0; // see [R20]
			else
			begin
				clr_next = 1'b1; // see [R16]
				done_next = 1'b1;
			end
		end

		if (op_set_pulse)
		begin
			crc_next = '0; // see [R24]
			lrc_next = '0;
			crc_flag_next = 1'b0;
			lrc_flag_next = 1'b0;
			end_next = 1'b0;
			stb_next = '0;
			many_next = 1'b0;
			gap_next = '0;
			seen_next = 1'b1; // see [R8]
			fmk_next = 1'b0;
			eor_next = trrc_pkg::EOR_PRESET;
			dd_next = 1'b0;
			done_next = 1'b0;
			crc_err_next = 1'b0;
			lrc_err_next = 1'b0;
			par_err_next = 1'b0;
			clr_next = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prev_reg <= '0;
			latch_reg <= '0;
			crc_reg <= '0;
			lrc_reg <= '0;
			crc_flag_reg <= 1'b0;
			lrc_flag_reg <= 1'b0;
			end_reg <= 1'b0;
			stb_reg <= '0;
			many_reg <= 1'b0;
			gap_reg <= '0;
			seen_reg <= 1'b1;
			fmk_reg <= 1'b0;
			eor_reg <= trrc_pkg::EOR_PRESET;
			dd_reg <= 1'b0;
			done_reg <= 1'b0;
			crc_err_reg <= 1'b0;
			lrc_err_reg <= 1'b0;
			par_err_reg <= 1'b0;
			chk_reg <= 1'b0;
			clr_reg <= 1'b0;
		end
		else
		begin
			prev_reg <= prev_next;
			latch_reg <= latch_next;
			crc_reg <= crc_next;
			lrc_reg <= lrc_next;
			crc_flag_reg <= crc_flag_next;
			lrc_flag_reg <= lrc_flag_next;
			end_reg <= end_next;
			stb_reg <= stb_next;
			many_reg <= many_next;
			gap_reg <= gap_next;
			seen_reg <= seen_next;
			fmk_reg <= fmk_next;
			eor_reg <= eor_next;
			dd_reg <= dd_next;
			done_reg <= done_next;
			crc_err_reg <= crc_err_next;
			lrc_err_reg <= lrc_err_next;
			par_err_reg <= par_err_next;
			chk_reg <= chk_next;
			clr_reg <= clr_next;
		end
	end

	// the drive cannot be paused; a full buffer drops the character
	trrc_pair_buf #(
		.W(trrc_pkg::CHAR_W)
	) u_buf (
		.clk(clk),
		.rst(rst),
		.in_valid(comp),
		.in_ready(char_buffer_ready),
		.in_data(ch),
		.out_valid(controller_data_strobe),
		.out_ready(ctrl_ready),
		.out_data(buf_out)
	);

	always_comb
	begin
		ctrl_char = reading ? buf_out : trrc_pkg::trrc_char_t'(lrc_reg); // see [R2]
		check_generator_pulse = chk_reg;
		latched_read_lines = latch_reg;
		crc_next_indication = crc_flag_reg;
		lrc_next_indication = lrc_flag_reg;
		crc_error_out = crc_err_reg;
		lrc_error_out = lrc_err_reg;
		parity_error_out = par_err_reg;
		file_mark_found_out = fmk_reg;
		more_than_two_strobes = many_reg;
		record_end_flag = end_reg;
		read_clear_pulse = clr_reg;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_CHK_FOLLOWS: assert property (comp |=> check_generator_pulse && latched_read_lines == $past(ch)) // see [R1]
		else $error("check pulse or latch missing after strobe");
	AST_MUX_LRC: assert property (!reading |-> ctrl_char == lrc_reg) // see [R2]
		else $error("idle mux not showing lrc");
	AST_CRC_ERR: assert property (comp && crc_flag_reg && forward_motion_active && !op_set_pulse
		&& (crc_reg != ch) |=> crc_error_out) // see [R3]
		else $error("crc mismatch not flagged");
	AST_LRC_ERR: assert property (comp && lrc_flag_reg && forward_motion_active && !op_set_pulse
		&& (lrc_reg != ch) |=> lrc_error_out) // see [R4]
		else $error("lrc mismatch not flagged");
	AST_ERR_FWD: assert property ($rose(crc_error_out) || $rose(lrc_error_out)
		|-> $past(forward_motion_active)) // see [R5]
		else $error("check error set without forward motion");
	AST_PAR_QUIET: assert property ((crc_flag_reg || lrc_flag_reg) && !par_err_reg
		|=> !parity_error_out) // see [R6]
		else $error("parity error during check phase");
	AST_FMK_SET: assert property ($rose(file_mark_found_out) |-> $past(stb_reg) == trrc_pkg::STB_GAP_ON
		&& $past(seen_reg)) // see [R7] see [R10]
		else $error("file mark without two mark characters");
	AST_SEEN_STAYS: assert property (!seen_reg && !op_set_pulse |=> !seen_reg) // see [R8]
		else $error("mark flag set again in same operation");
	AST_THIRD: assert property (drv_stb && stb_reg == trrc_pkg::STB_GAP_ON && !op_set_pulse
		|=> more_than_two_strobes && gap_reg == '0) // see [R9]
		else $error("third strobe did not reset gap detector");
	AST_THREE_START: assert property (three_evt && !op_set_pulse
		|=> crc_next_indication != lrc_next_indication) // see [R12] see [R13] see [R21]
		else $error("three count did not start end sequence");
	AST_CRC_TO_LRC: assert property (comp && crc_flag_reg && !op_set_pulse
		|=> lrc_next_indication && !crc_next_indication) // see [R14]
		else $error("crc strobe did not enter lrc phase");
	AST_LRC_END: assert property (comp && lrc_flag_reg && !op_set_pulse
		|=> record_end_flag && !lrc_next_indication ##1 !crc_next_indication) // see [R15]
		else $error("lrc strobe did not end record");
	AST_CLR_ONCE: assert property (read_clear_pulse |=> !read_clear_pulse) // see [R16]
		else $error("clear pulse longer than one cycle");
endmodule : trrc_top
